// >>> logic/wdsvc_pkg.sv
// wdsvc_pkg: register map, field positions, reset values and constants
// for the watchdog service block. assumes a 32-bit apb bus, word aligned.
package wdsvc_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CSR = 12'h000;
    localparam logic [11:0] ADDR_RELOAD = 12'h004;
    localparam logic [11:0] ADDR_SERVICE = 12'h008;
    localparam logic [11:0] ADDR_CONFIG = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CSR_IRQ_EN_BIT = 3;
    localparam int CSR_PENDING_BIT = 4;
    localparam int CSR_FREEZE_EN_BIT = 5;
    localparam int CFG_MATCH_EN_BIT = 0;
    localparam int STS_RUN_BIT = 0;
    localparam int STS_ERR_BIT = 1;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [7:0] RELOAD_RST = 8'h0f;
    localparam logic [7:0] SERVICE_PATTERN = 8'h5c;
    localparam logic [7:0] PRESCALE_RST = 8'hff;
    localparam logic [1:0] SYNC_RST = 2'h0;

    // ------------------------------------------------------------
    // control bits carried together
    // ------------------------------------------------------------
    typedef struct packed {
        logic freeze_halt_enable;
        logic prescale_timer_irq_enable;
        logic match_service_enable;
    } wdsvc_ctrl_s;

    // request kinds crossing into the watchdog tick domain
    typedef enum logic [2:0] {
        REQ_IDLE = 3'h1,
        REQ_RELOAD = 3'h2,
        REQ_SERVICE = 3'h4
    } wdsvc_req_e;

endpackage

// >>> logic/wdsvc_top.sv
// wdsvc_top: watchdog reload and match servicing, prescale timer control bits.
// assumes an apb master on pclk, and wd_clk_in / freeze_in asynchronous pins.
// wd_clk_in must stay well below a quarter of pclk or ticks are lost.
// freeze_in is a level; the halt follows it two pclk cycles late.
//
// Summary of operation
// - freeze enable set halts prescale timer while freeze input asserted
// - freeze enable bit resets to zero
// - reload register is eight bits, write only
// - watchdog idle after reset, starts on first reload write
// - each later reload write restarts count with new value
// - reload register resets to 0fh
// - with match enabled, writing 5ch to service register services watchdog
// - valid service reloads counter from stored reload value
// - with match enabled, any other byte raises watchdog error
// - with match enabled, two service writes within one watchdog clock cycle raise error
// - with match disabled, service writes are ignored entirely
`timescale 1ns/10ps

module wdsvc_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins from outside the clock domain
    input wire logic wd_clk_in,
    input wire logic freeze_in,
    // event outputs
    output logic prescale_irq,
    output logic wd_error,
    output logic wd_expired
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] wdclk_sync_r;
    logic [1:0] frz_sync_r;
    logic wdclk_prev_r;
    logic wd_tick;
    logic freeze_s;

    // first stage feeds only the second stage
    // hazard: a pin pulse shorter than one pclk period can be missed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdclk_sync_r <= wdsvc_pkg::SYNC_RST;
            frz_sync_r <= wdsvc_pkg::SYNC_RST;
            wdclk_prev_r <= 1'b0;
        end else begin
            wdclk_sync_r <= {wdclk_sync_r[0], wd_clk_in};
            frz_sync_r <= {frz_sync_r[0], freeze_in};
            wdclk_prev_r <= wdclk_sync_r[1];
        end
    end

    // rising edge of the watchdog input clock as a one-cycle enable
    assign wd_tick = wdclk_sync_r[1] & ~wdclk_prev_r;
    assign freeze_s = frz_sync_r[1];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // zero wait state slave: access phase completes in its first cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    // read data is latched in the setup cycle, so it stands through access
    assign rd_en = psel & ~penable & ~pwrite;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == wdsvc_pkg::ADDR_CSR) || (a == wdsvc_pkg::ADDR_RELOAD) ||
                    (a == wdsvc_pkg::ADDR_SERVICE) || (a == wdsvc_pkg::ADDR_CONFIG) ||
                    (a == wdsvc_pkg::ADDR_STATUS);
    endfunction

    assign addr_ok = is_mapped(paddr);
    // writes to the read-only status word are accepted and have no effect
    assign pslverr = psel & penable & ~addr_ok;

    // one compare for every register strobe, so no decode drifts from the map
    function automatic logic strobe_at(input logic en, input logic [11:0] a,
                                       input logic [11:0] target);
        strobe_at = en & (a == target);
    endfunction

    logic wr_csr;
    logic wr_reload;
    logic wr_service;
    logic wr_cfg;
    assign wr_csr = strobe_at(wr_en, paddr, wdsvc_pkg::ADDR_CSR);
    assign wr_reload = strobe_at(wr_en, paddr, wdsvc_pkg::ADDR_RELOAD);
    assign wr_service = strobe_at(wr_en, paddr, wdsvc_pkg::ADDR_SERVICE);
    assign wr_cfg = strobe_at(wr_en, paddr, wdsvc_pkg::ADDR_CONFIG);

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    wdsvc_pkg::wdsvc_ctrl_s ctrl_r;

    // all control bits clear at reset, so freeze is ignored by default
    // match enable lives in the config word, not the control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
        end else begin
            if (wr_csr) begin
                ctrl_r.freeze_halt_enable <= pwdata[wdsvc_pkg::CSR_FREEZE_EN_BIT];
                ctrl_r.prescale_timer_irq_enable <= pwdata[wdsvc_pkg::CSR_IRQ_EN_BIT];
            end
            if (wr_cfg) begin
                ctrl_r.match_service_enable <= pwdata[wdsvc_pkg::CFG_MATCH_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // counter helpers shared by both down counters
    // ------------------------------------------------------------
    // one step down; callers gate it, so no underflow guard here
    function automatic logic [7:0] count_down(input logic [7:0] v);
        count_down = v - 8'h01;
    endfunction

    // zero test for the wrap pulse, the expiry level and the stop
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

    // ------------------------------------------------------------
    // prescale timer
    // ------------------------------------------------------------
    logic [7:0] pt_count_r;
    logic pt_run;

    // freeze only bites when enabled; otherwise count through debug halts
    assign pt_run = wd_tick & ~(ctrl_r.freeze_halt_enable & freeze_s);

    // free running down counter; no preset register in this block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pt_count_r <= wdsvc_pkg::PRESCALE_RST;
        end else if (pt_run) begin
            pt_count_r <= count_down(pt_count_r);
        end
    end

    // one pulse per wrap through zero, only while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_irq <= 1'b0;
        end else begin
            prescale_irq <= pt_run & is_zero(pt_count_r) &
                            ctrl_r.prescale_timer_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // reload register and service write capture
    // ------------------------------------------------------------
    logic [7:0] reload_r;
    logic svc_good;
    logic svc_bad;

    // write only; never returned on reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_r <= wdsvc_pkg::RELOAD_RST;
        end else if (wr_reload) begin
            reload_r <= pwdata[7:0];
        end
    end

    // the service byte compare feeds both the good and the bad path
    function automatic logic is_pattern(input logic [7:0] b);
        is_pattern = (b == wdsvc_pkg::SERVICE_PATTERN);
    endfunction

    // writes with matching disabled are dropped here, no service no error
    assign svc_good = wr_service & ctrl_r.match_service_enable &
                      is_pattern(pwdata[7:0]);
    assign svc_bad = wr_service & ctrl_r.match_service_enable &
                     ~is_pattern(pwdata[7:0]);

    // ------------------------------------------------------------
    // request held until the next watchdog tick
    // ------------------------------------------------------------
    wdsvc_pkg::wdsvc_req_e req_r;
    logic svc_seen_r;
    logic double_svc;

    // a second good service before the tick consumes the first is an error
    assign double_svc = svc_good & svc_seen_r;

    // one-hot request held until the tick carries it into the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r <= wdsvc_pkg::REQ_IDLE;
        end else begin
            case (req_r)
                wdsvc_pkg::REQ_IDLE: begin
                    if (wr_reload) begin
                        req_r <= wdsvc_pkg::REQ_RELOAD;
                    end else if (svc_good) begin
                        req_r <= wdsvc_pkg::REQ_SERVICE;
                    end
                end
                wdsvc_pkg::REQ_RELOAD, wdsvc_pkg::REQ_SERVICE: begin
                    // new writes win over the tick so none is lost; a service
                    // that lands on the tick that consumes a reload waits a tick
                    if (wr_reload) begin
                        req_r <= wdsvc_pkg::REQ_RELOAD;
                    end else if (svc_good && (req_r == wdsvc_pkg::REQ_SERVICE || wd_tick)) begin
                        req_r <= wdsvc_pkg::REQ_SERVICE;
                    end else if (wd_tick) begin
                        req_r <= wdsvc_pkg::REQ_IDLE;
                    end
                end
                default: begin
                    req_r <= wdsvc_pkg::REQ_IDLE;
                end
            endcase
        end
    end

    // tracks whether a service already landed in this watchdog cycle
    // the set wins over the tick, so a write on the tick opens the window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_seen_r <= 1'b0;
        end else if (svc_good) begin
            svc_seen_r <= 1'b1;
        end else if (wd_tick) begin
            svc_seen_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // watchdog counter on tick enable
    // ------------------------------------------------------------
    logic [7:0] wd_count_r;
    logic wd_run_r;

    // idle until the first reload write; service before start is inert
    // a service before start only retires its own request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_run_r <= 1'b0;
        end else if (wd_tick && req_r == wdsvc_pkg::REQ_RELOAD) begin
            wd_run_r <= 1'b1;
        end
    end

    // count stops at zero rather than wrapping, so expiry stays a level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_count_r <= wdsvc_pkg::RELOAD_RST;
        end else if (wd_tick) begin
            if (req_r == wdsvc_pkg::REQ_RELOAD) begin
                wd_count_r <= reload_r;
            end else if (req_r == wdsvc_pkg::REQ_SERVICE && wd_run_r) begin
                wd_count_r <= reload_r;
            end else if (wd_run_r && !is_zero(wd_count_r)) begin
                wd_count_r <= count_down(wd_count_r);
            end
        end
    end

    // expiry level: running and counted out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_expired <= 1'b0;
        end else begin
            wd_expired <= wd_run_r & is_zero(wd_count_r);
        end
    end

    // ------------------------------------------------------------
    // error flag, sticky until written one to clear
    // ------------------------------------------------------------
    logic err_set;
    assign err_set = svc_bad | double_svc;

    // set wins over a clear in the same cycle
    // the clear rides on the config word, in its second bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_error <= 1'b0;
        end else if (err_set) begin
            wd_error <= 1'b1;
        end else if (wr_cfg && pwdata[wdsvc_pkg::STS_ERR_BIT]) begin
            wd_error <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic pending;
    // high from the write edge until the tick that carries it
    assign pending = (req_r != wdsvc_pkg::REQ_IDLE);

    // write-only and unmapped offsets read zero; data drops after access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= 32'h0000_0000;
            if (rd_en) begin
                case (paddr)
                    wdsvc_pkg::ADDR_CSR: begin
                        prdata[wdsvc_pkg::CSR_FREEZE_EN_BIT] <= ctrl_r.freeze_halt_enable;
                        prdata[wdsvc_pkg::CSR_PENDING_BIT] <= pending;
                        prdata[wdsvc_pkg::CSR_IRQ_EN_BIT] <= ctrl_r.prescale_timer_irq_enable;
                    end
                    wdsvc_pkg::ADDR_CONFIG: begin
                        prdata[wdsvc_pkg::CFG_MATCH_EN_BIT] <= ctrl_r.match_service_enable;
                    end
                    wdsvc_pkg::ADDR_STATUS: begin
                        prdata[wdsvc_pkg::STS_RUN_BIT] <= wd_run_r;
                        prdata[wdsvc_pkg::STS_ERR_BIT] <= wd_error;
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

endmodule // wdsvc_top

// >>> testbench/wdsvc_asserts.sv
// wdsvc_asserts: port-level checks on the watchdog service block.
// assumes it is bound into wdsvc_top and sees only that module's ports.
`timescale 1ns/10ps

module wdsvc_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // events
    input wire logic prescale_irq,
    input wire logic wd_error,
    input wire logic wd_expired
);
    // ------------------------------------------------------------
    // shadow of the control bits
    // ------------------------------------------------------------
    wire logic wr_hit = psel && penable && pwrite;
    wire logic rd_hit = psel && penable && !pwrite;
    wire logic clr_wr = wr_hit && paddr == wdsvc_pkg::ADDR_CONFIG && pwdata[1];
    logic match_r, frz_r, irq_r, started_r;

    // mirrors follow apb writes; the design's own copy is never trusted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {match_r, frz_r, irq_r, started_r} <= 4'h0;
        end else if (wr_hit) begin
            if (paddr == wdsvc_pkg::ADDR_CONFIG) match_r <= pwdata[0];
            if (paddr == wdsvc_pkg::ADDR_CSR) {frz_r, irq_r} <= {pwdata[5], pwdata[3]};
            if (paddr == wdsvc_pkg::ADDR_RELOAD) started_r <= 1'b1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_reload_reads_zero: assert property (
        rd_hit && paddr == wdsvc_pkg::ADDR_RELOAD |-> prdata == 32'h0)
        else $error("reload register read back nonzero");
    a_csr_bits_track: assert property (
        rd_hit && paddr == wdsvc_pkg::ADDR_CSR |-> prdata[5] == frz_r && prdata[3] == irq_r)
        else $error("control bits differ from last write");
    a_bad_byte_error: assert property (
        wr_hit && paddr == wdsvc_pkg::ADDR_SERVICE && match_r
        && pwdata[7:0] != wdsvc_pkg::SERVICE_PATTERN |-> ##[1:2] wd_error)
        else $error("wrong service byte left error low");
    a_disabled_quiet: assert property (
        wr_hit && paddr == wdsvc_pkg::ADDR_SERVICE && !match_r && !wd_error |=> !wd_error)
        else $error("service write with matching off raised error");
    a_error_held: assert property ($fell(wd_error) |-> $past(clr_wr))
        else $error("error dropped without a clear write");
    a_idle_no_expiry: assert property (!started_r |-> !wd_expired)
        else $error("watchdog expired before it was started");
    a_irq_gated: assert property (prescale_irq |-> irq_r || $past(irq_r))
        else $error("timer interrupt while disabled");
    a_irq_pulse: assert property (prescale_irq |=> !prescale_irq)
        else $error("timer interrupt longer than one cycle");
endmodule // wdsvc_asserts

bind wdsvc_top wdsvc_asserts u_wdsvc_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .prescale_irq(prescale_irq), .wd_error(wd_error), .wd_expired(wd_expired));

// >>> testbench/test_watchdog_service_and_t0_control.sv
// test_watchdog_service_and_t0_control: directed bench for wdsvc_top.
// assumes the checker file is compiled too and binds itself to uut.
`timescale 1ns/10ps

module test_watchdog_service_and_t0_control;
    // ------------------------------------------------------------
    // stimulus, observation and counters
    // ------------------------------------------------------------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic wd_clk_in = 1'b0, freeze_in = 1'b0, pready, pslverr, prescale_irq, wd_error;
    logic wd_expired, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] wdiv = 4'h0;
    int mismatches = 0, check_count = 0, cycles = 0, irq_cnt = 0, base;

    wdsvc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wd_clk_in(wd_clk_in), .freeze_in(freeze_in),
        .prescale_irq(prescale_irq), .wd_error(wd_error), .wd_expired(wd_expired));

    always #10 pclk = ~pclk;

    // watchdog pin at pclk/16, well under the synchroniser's limit
    always @(posedge pclk) begin
        wdiv <= wdiv + 4'h1;
        wd_clk_in <= wdiv[3];
        cycles <= cycles + 1;
        if (prescale_irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cycles == 40000) begin
            mismatches++;
            $display("mismatch timeout expected below %0d seen %0d", 40000, cycles);
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; ends just past the completing edge so outputs have landed
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            $display("mismatch pready expected 1 seen %b", pready);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, rdat);
    endtask

    task ticks(input int n);
        repeat (n * 16) @(posedge pclk);
    endtask

    // start work mid-period so no tick lands between two close writes
    task align;
        do @(posedge pclk); while (wdiv !== 4'h8);
        repeat (4) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd(wdsvc_pkg::ADDR_CSR, 32'h0, "csr");
        rd(wdsvc_pkg::ADDR_RELOAD, 32'h0, "reload");
        ticks(20);
        rd(wdsvc_pkg::ADDR_STATUS, 32'h0, "status idle");
        chk("expired idle", 32'h0, {31'h0, wd_expired});
        xfer(1'b0, 12'h0f0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask

    task t_reload;
        align;
        wr(wdsvc_pkg::ADDR_RELOAD, 32'h3);
        rd(wdsvc_pkg::ADDR_CSR, 32'h10, "pending set");
        ticks(2);
        rd(wdsvc_pkg::ADDR_CSR, 32'h0, "pending clear");
        rd(wdsvc_pkg::ADDR_STATUS, 32'h1, "running");
        ticks(6);
        chk("expired", 32'h1, {31'h0, wd_expired});
        wr(wdsvc_pkg::ADDR_RELOAD, 32'h5);
        ticks(2);
        chk("restarted", 32'h0, {31'h0, wd_expired});
        ticks(8);
        chk("expired again", 32'h1, {31'h0, wd_expired});
        $display("test reload done");
    endtask

    task t_service;
        wr(wdsvc_pkg::ADDR_CONFIG, 32'h1);
        rd(wdsvc_pkg::ADDR_CONFIG, 32'h1, "match enable");
        wr(wdsvc_pkg::ADDR_RELOAD, 32'h4);
        repeat (6) begin
            ticks(2);
            wr(wdsvc_pkg::ADDR_SERVICE, 32'h5c);
        end
        chk("serviced", 32'h0, {30'h0, wd_error, wd_expired});
        ticks(8);
        chk("starved", 32'h1, {31'h0, wd_expired});
        wr(wdsvc_pkg::ADDR_SERVICE, 32'h5c);
        ticks(2);
        chk("revived", 32'h0, {31'h0, wd_expired});
        $display("test service done");
    endtask

    task t_errors;
        wr(wdsvc_pkg::ADDR_SERVICE, 32'ha3);
        ticks(1);
        chk("bad byte", 32'h1, {31'h0, wd_error});
        rd(wdsvc_pkg::ADDR_STATUS, 32'h3, "status error");
        wr(wdsvc_pkg::ADDR_CONFIG, 32'h3);
        ticks(1);
        chk("cleared", 32'h0, {31'h0, wd_error});
        align;
        wr(wdsvc_pkg::ADDR_SERVICE, 32'h5c);
        wr(wdsvc_pkg::ADDR_SERVICE, 32'h5c);
        ticks(1);
        chk("double", 32'h1, {31'h0, wd_error});
        wr(wdsvc_pkg::ADDR_CONFIG, 32'h2);
        wr(wdsvc_pkg::ADDR_SERVICE, 32'ha3);
        wr(wdsvc_pkg::ADDR_SERVICE, 32'h5c);
        wr(wdsvc_pkg::ADDR_SERVICE, 32'h5c);
        rd(wdsvc_pkg::ADDR_CSR, 32'h0, "no service taken");
        ticks(1);
        chk("disabled", 32'h0, {31'h0, wd_error});
        $display("test errors done");
    endtask

    // a full prescale wrap takes 256 ticks, so each window holds at least one
    task t_timer;
        @(posedge pclk);
        freeze_in <= 1'b1;
        wr(wdsvc_pkg::ADDR_CSR, 32'h28);
        rd(wdsvc_pkg::ADDR_CSR, 32'h28, "csr bits");
        base = irq_cnt;
        ticks(300);
        chk("frozen", 32'h0, 32'(irq_cnt - base));
        @(posedge pclk);
        freeze_in <= 1'b0;
        base = irq_cnt;
        ticks(260);
        chk("irq on", 32'h1, 32'(irq_cnt != base));
        wr(wdsvc_pkg::ADDR_CSR, 32'h0);
        base = irq_cnt;
        ticks(260);
        chk("irq off", 32'h0, 32'(irq_cnt - base));
        @(posedge pclk);
        freeze_in <= 1'b1;
        wr(wdsvc_pkg::ADDR_CSR, 32'h8);
        base = irq_cnt;
        ticks(260);
        chk("freeze ignored", 32'h1, 32'(irq_cnt != base));
        $display("test timer done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_reload();
        t_service();
        t_errors();
        t_timer();
        end_of_test();
    end
endmodule // test_watchdog_service_and_t0_control
